// *** srf_result_fifo.sv ***
// Spectral result queue: packs selected per-sample results into a
// 128-entry queue of 16-bit words read through the register port.
// Assumes the register port and sample source share this clock.
//
// How it works
// - Select bits 1-6 queue channels zero-five
// - Select bit 0 queues the status byte
// - Select resets zero; bit 7 reads zero
// - Fill count tracks unread two-byte entries
// - Queue holds 128 entries, 256 bytes
// - Fill count readable at 0xFD, resets zero
// - Low byte at 0xFE, high at 0xFF
// - Entry into full queue: flag, discard
// - Address pointer wraps 0xFF back to 0xFE
// - Reading 0xFF pops one entry
// - Empty queue reads zero, read index unchanged
`timescale 1ns/100ps
`default_nettype none
`include "srf_consts.svh"

module srf_result_fifo
   import srf_pkg::*;
(
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        reg_ptr_load,
   input  wire logic [7:0]                  reg_addr,
   input  wire logic                        reg_rd,
   input  wire logic                        reg_wr,
   input  wire logic [7:0]                  reg_wdata,
   output logic      [7:0]                  reg_rdata,
   output logic      [7:0]                  reg_ptr,
   input  wire logic                        sample_valid,
   input  wire logic [`SRF_NUM_CHAN*16-1:0] sample_chan,
   input  wire logic [7:0]                  sample_gain_saturation_status,
   output logic                             sample_ready,
   output logic      [7:0]                  queue_fill_count,
   output logic                             queue_overflow_flag
);

   srf_state_t              s;
   srf_state_t              next_s;
   logic [`SRF_ENTRY_W-1:0] queue_mem [0:`SRF_QUEUE_ENTRIES-1];
   logic [`SRF_ENTRY_W-1:0] queue_read_word;
   logic [`SRF_ENTRY_W-1:0] push_data;
   logic                    push_valid;
   logic                    push_ready;
   logic [`SRF_ENTRY_W-1:0] drain_data;
   logic                    drain_valid;
   logic                    drain_ready;
   logic                    drain_take;
   logic                    drain_store;
   logic                    pop;
   logic                    data_read;
   logic                    access;
   logic [`SRF_NUM_SRC-1:0] low_bit;
   logic [`SRF_NUM_SRC-1:0] cand [0:`SRF_NUM_SRC-1];
   logic [`SRF_ENTRY_W-1:0] src_word [0:`SRF_NUM_SRC-1];

   ////////////////////////////////////////////////////////////////////////
   // Source words and lowest pending source
   assign src_word[`SRF_SEL_STATUS_BIT] = {8'h00, s.stat};
   assign cand[0] = {{(`SRF_NUM_SRC-1){1'b0}}, s.mask[0]};

   genvar g;
   generate
      for (g = 1; g < `SRF_NUM_SRC; g++) begin : g_src
         assign src_word[g] = s.chan[(g-1)*16 +: 16];
         assign cand[g] = s.mask[g] && (s.mask[g-1:0] == '0) ?
                          (`SRF_NUM_SRC'(1) << g) : cand[g-1];
      end
   endgenerate

   assign low_bit = cand[`SRF_NUM_SRC-1];

   always_comb begin
      push_data = '0;
      for (int i = 0; i < `SRF_NUM_SRC; i++) begin
         if (low_bit[i]) begin
            push_data = src_word[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Staging buffer; the queue write stalls on pop cycles
   srf_stage_fifo #(
      .WIDTH (`SRF_ENTRY_W),
      .DEPTH (`SRF_STAGE_DEPTH)
   ) srf_stage_fifo_i (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   (push_data),
      .out_valid (drain_valid),
      .out_ready (drain_ready),
      .out_data  (drain_data)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_s          = s;
      queue_read_word = queue_mem[s.rd_idx];
      access          = !reg_ptr_load && (reg_rd || reg_wr);
      data_read       = !reg_ptr_load && reg_rd &&
                        (s.ptr == `SRF_ADDR_DATA_LOW || s.ptr == `SRF_ADDR_DATA_HIGH);
      pop             = !reg_ptr_load && reg_rd && s.ptr == `SRF_ADDR_DATA_HIGH &&
                        s.level != 8'h00;
      // Single-ported queue: a pop cycle holds off the drain
      drain_ready     = !pop;
      drain_take      = drain_valid && drain_ready;
      drain_store     = drain_take && s.level != 8'(`SRF_QUEUE_ENTRIES);
      push_valid      = (s.ser == SRF_SER_SEND) && (s.mask != '0);

      // Register pointer
      if (reg_ptr_load) begin
         next_s.ptr = reg_addr;
      end else if (access) begin
         next_s.ptr = (s.ptr == `SRF_ADDR_DATA_HIGH) ? `SRF_ADDR_DATA_LOW : s.ptr + 8'h01;
      end

      // Register write
      if (access && reg_wr && s.ptr == `SRF_ADDR_SELECT) begin
         next_s.sel = reg_wdata & 8'h7F;
      end

      // Register read
      if (access && reg_rd) begin
         case (s.ptr)
            `SRF_ADDR_SELECT:    next_s.rdata = s.sel;
            `SRF_ADDR_FILL:      next_s.rdata = s.level;
            `SRF_ADDR_DATA_LOW:  next_s.rdata = (s.level != 8'h00) ? queue_read_word[7:0] : 8'h00;
            `SRF_ADDR_DATA_HIGH: next_s.rdata = (s.level != 8'h00) ? queue_read_word[15:8] : 8'h00;
            default:             next_s.rdata = 8'h00;
         endcase
      end

      // Queue pointers and fill count
      if (pop) begin
         next_s.rd_idx = s.rd_idx + 1'b1;
         next_s.level  = s.level - 8'h01;
      end
      if (drain_store) begin
         next_s.wr_idx = s.wr_idx + 1'b1;
         next_s.level  = s.level + 8'h01;
      end

      // Read clears the flag, a discard in the same cycle wins
      if (data_read) begin
         next_s.ovf = 1'b0;
      end
      if (drain_take && !drain_store) begin
         next_s.ovf = 1'b1;
      end

      // Sample unpacking
      case (s.ser)
         SRF_SER_IDLE: begin
            if (sample_valid && s.sel[`SRF_NUM_SRC-1:0] != '0) begin
               next_s.mask = s.sel[`SRF_NUM_SRC-1:0];
               next_s.chan = sample_chan;
               next_s.stat = sample_gain_saturation_status;
               next_s.ser  = SRF_SER_SEND;
            end
         end
         SRF_SER_SEND: begin
            if (push_ready) begin
               next_s.mask = s.mask & ~low_bit;
               if ((s.mask & ~low_bit) == '0) begin
                  next_s.ser = SRF_SER_IDLE;
               end
            end
         end
         default: begin
            next_s.ser = SRF_SER_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s        <= '0;
         s.sel    <= `SRF_SELECT_RESET;
         s.level  <= `SRF_FILL_RESET;
         s.rdata  <= `SRF_RDATA_RESET;
         s.ser    <= SRF_SER_IDLE;
      end else begin
         s <= next_s;
      end
   end

   always_ff @(posedge clock) begin
      if (drain_store) begin
         queue_mem[s.wr_idx] <= drain_data;
      end
   end

   assign reg_rdata           = s.rdata;
   assign reg_ptr             = s.ptr;
   assign queue_fill_count    = s.level;
   assign queue_overflow_flag = s.ovf;
   assign sample_ready        = (s.ser == SRF_SER_IDLE);

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sel_reserved_a: assert property (s.sel[`SRF_SEL_RSVD_BIT] == 1'b0)
      else $error("Reserved select bit set");
   level_bound_a: assert property (s.level <= 8'(`SRF_QUEUE_ENTRIES))
      else $error("Fill count above queue size");
   fill_read_a: assert property (!reg_ptr_load && reg_rd && s.ptr == `SRF_ADDR_FILL
         |=> reg_rdata == $past(queue_fill_count))
      else $error("Fill count read wrong");
   ptr_wrap_a: assert property (access && s.ptr == `SRF_ADDR_DATA_HIGH
         |=> reg_ptr == `SRF_ADDR_DATA_LOW)
      else $error("Pointer did not wrap to low byte");
   high_pop_a: assert property (pop |=> queue_fill_count == $past(queue_fill_count) - 8'h01
         && s.rd_idx == $past(s.rd_idx) + 1'b1)
      else $error("High byte read did not pop");
   empty_read_a: assert property (data_read && s.level == 8'h00
         |=> reg_rdata == 8'h00 && $stable(s.rd_idx))
      else $error("Empty read not zero");
   low_data_a: assert property (data_read && s.ptr == `SRF_ADDR_DATA_LOW && s.level != 8'h00
         |=> reg_rdata == $past(queue_read_word[7:0]) && $stable(s.rd_idx))
      else $error("Low byte read wrong");
   overflow_set_a: assert property (drain_take && s.level == 8'(`SRF_QUEUE_ENTRIES)
         |=> queue_overflow_flag && queue_fill_count == 8'(`SRF_QUEUE_ENTRIES))
      else $error("Overflow not flagged");
   level_grow_a: assert property (drain_store |=> queue_fill_count == $past(queue_fill_count) + 8'h01)
      else $error("Fill count did not grow");
   status_first_a: assert property (push_valid && s.mask[`SRF_SEL_STATUS_BIT]
         |-> push_data == {8'h00, s.stat})
      else $error("Status not pushed first");
   sample_take_a: assert property (sample_ready && sample_valid && s.sel[6:1] != 6'h00
         |=> s.mask[6:1] == $past(s.sel[6:1]) && push_valid)
      else $error("Selected channels not queued");
   status_take_a: assert property (sample_ready && sample_valid && s.sel[0]
         |=> s.mask[0] && push_valid)
      else $error("Status not queued");


   // Register port
   sel_write_a: assert property (
      access && reg_wr && s.ptr == `SRF_ADDR_SELECT |=> s.sel == ($past(reg_wdata) & 8'h7F))
      else $error("Select write not stored");
   unmapped_read_a: assert property (
      access && reg_rd && s.ptr < `SRF_ADDR_SELECT |=> reg_rdata == 8'h00)
      else $error("Unmapped read not zero");
   ptr_step_a: assert property (
      access && s.ptr != `SRF_ADDR_DATA_HIGH |=> reg_ptr == $past(s.ptr) + 8'h01)
      else $error("Pointer did not step");
   ptr_load_a: assert property (
      reg_ptr_load |=> reg_ptr == $past(reg_addr))
      else $error("Pointer not loaded");
   ptr_hold_a: assert property (
      !reg_ptr_load && !access |=> $stable(reg_ptr))
      else $error("Pointer moved without access");
   // Queue, flag and unpacking; a drop must leave the queue untouched
   ovf_clear_a: assert property (
      data_read && !(drain_take && !drain_store) |=> !queue_overflow_flag)
      else $error("Overflow not cleared by read");
   ovf_sticky_a: assert property (
      queue_overflow_flag && !data_read |=> queue_overflow_flag)
      else $error("Overflow flag lost");
   wr_drop_a: assert property (
      drain_take && !drain_store |=> $stable(s.wr_idx))
      else $error("Discarded entry was written");
   empty_no_pop_a: assert property (
      data_read && s.level == 8'h00 |=> queue_fill_count == 8'h00)
      else $error("Empty read changed fill count");
   rd_idx_hold_a: assert property (
      !pop |=> $stable(s.rd_idx))
      else $error("Read index moved without pop");
   level_hold_a: assert property (
      !pop && !drain_store |=> $stable(s.level))
      else $error("Fill count moved without event");
   busy_drop_a: assert property (
      !sample_ready |=> $stable(s.chan) && $stable(s.stat))
      else $error("Sample taken while unpacking");
   chan_order_a: assert property (
      push_valid && !s.mask[0] && s.mask[1] |-> push_data == s.chan[15:0])
      else $error("Channel zero not pushed next");
   ready_drop_a: assert property (
      sample_ready && sample_valid && s.sel[6:0] != 7'h00 |=> !sample_ready)
      else $error("Ready did not drop on sample");

   overflow_c: cover property (drain_take && !drain_store);
   pop_c: cover property (pop ##1 pop);
   full_sample_c: cover property (sample_valid && sample_ready && s.sel == 8'h7F);
   stage_full_c: cover property (push_valid && !push_ready);
   busy_drop_c: cover property (sample_valid && !sample_ready);

endmodule

`default_nettype wire

// *** srf_consts.svh ***
// Constants for the spectral result queue: addresses, field positions,
// reset values and sizes. Included by the package and the result queue module.
`ifndef SRF_CONSTS_SVH
`define SRF_CONSTS_SVH

`define SRF_ADDR_SELECT      8'hFC
`define SRF_ADDR_FILL        8'hFD
`define SRF_ADDR_DATA_LOW    8'hFE
`define SRF_ADDR_DATA_HIGH   8'hFF

`define SRF_SEL_STATUS_BIT   0
`define SRF_SEL_CHAN_LSB     1
`define SRF_SEL_RSVD_BIT     7
`define SRF_NUM_CHAN         6
`define SRF_NUM_SRC          7

`define SRF_SELECT_RESET     8'h00
`define SRF_FILL_RESET       8'h00
`define SRF_RDATA_RESET      8'h00

`define SRF_QUEUE_BYTES      256
`define SRF_QUEUE_ENTRIES    128
`define SRF_QUEUE_IDX_W      7
`define SRF_STAGE_DEPTH      16
`define SRF_ENTRY_W          16

`endif

// *** srf_pkg.sv ***
// Types used by the spectral result queue module.
// Assumes srf_consts.svh is on the include path.
`include "srf_consts.svh"

package srf_pkg;

   typedef enum logic {
      SRF_SER_IDLE,
      SRF_SER_SEND
   } srf_ser_t;

   typedef struct packed {
      logic [7:0]                         ptr;
      logic [7:0]                         sel;
      logic [7:0]                         rdata;
      logic [7:0]                         level;
      logic [`SRF_QUEUE_IDX_W-1:0]        wr_idx;
      logic [`SRF_QUEUE_IDX_W-1:0]        rd_idx;
      logic                               ovf;
      srf_ser_t                           ser;
      logic [`SRF_NUM_SRC-1:0]            mask;
      logic [`SRF_NUM_CHAN*16-1:0]        chan;
      logic [7:0]                         stat;
   } srf_state_t;

endpackage

// *** srf_stage_fifo.sv ***
// Small staging FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module srf_stage_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } srf_fifo_state_t;

   srf_fifo_state_t s;
   srf_fifo_state_t next_s;
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic             do_push;
   logic             do_pop;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      in_ready  = (s.cnt != (AW+1)'(DEPTH));
      out_valid = (s.cnt != '0);
      out_data  = mem[s.rp];
      do_push   = in_valid && in_ready;
      do_pop    = out_valid && out_ready;
      next_s    = s;
      if (do_push) begin
         next_s.wp = (s.wp == AW'(DEPTH-1)) ? '0 : s.wp + 1'b1;
      end
      if (do_pop) begin
         next_s.rp = (s.rp == AW'(DEPTH-1)) ? '0 : s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Storage has no reset; contents are only read behind a valid count
   always_ff @(posedge clock) begin
      if (do_push) begin
         mem[s.wp] <= in_data;
      end
   end

endmodule

`default_nettype wire

// *** srf_host_model.sv ***
// Host model: drives the register port of the result queue.
// Assumes the bench calls its tasks; pins change at falling edges.
`timescale 1ns/100ps
`default_nettype none

module srf_host_model (
   input  wire logic       clock,
   output logic            reg_ptr_load,
   output logic [7:0]      reg_addr,
   output logic            reg_rd,
   output logic            reg_wr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_ptr_load = 1'b0;
      reg_rd       = 1'b0;
      reg_wr       = 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Released lines show the inverse, never a stale copy
   task automatic load(input logic [7:0] a);
      @(negedge clock);
      reg_ptr_load = 1'b1;
      reg_addr     = a;
      @(negedge clock);
      reg_ptr_load = 1'b0;
      reg_addr     = ~a;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      load(a);
      @(negedge clock);
      reg_wr    = 1'b1;
      reg_wdata = d;
      @(negedge clock);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask

   // One read strobe at the current pointer, then samples the byte registered at the next edge
   task automatic rd(output logic [7:0] d);
      @(negedge clock);
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      d      = reg_rdata;
   endtask
endmodule
`default_nettype wire

// *** srf_result_fifo_tb_top.sv ***
// Testbench for the spectral result queue: register reads and checks.
// Assumes the host model drives the register port at falling edges.
`timescale 1ns/100ps
`default_nettype none

module srf_result_fifo_tb_top;
   logic        clock, rst_n, sample_valid, ready, ovf;
   logic        reg_ptr_load, reg_rd, reg_wr;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, reg_ptr, st_in, fill;
   logic [95:0] chan;
   logic [15:0] w;
   int          n_errors = 0, n_tests = 0, cyc = 0, e, s;

   srf_result_fifo srf_result_fifo_i (.clock(clock), .rst_n(rst_n),
      .reg_ptr_load(reg_ptr_load), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ptr(reg_ptr), .sample_valid(sample_valid), .sample_chan(chan),
      .sample_gain_saturation_status(st_in), .sample_ready(ready),
      .queue_fill_count(fill), .queue_overflow_flag(ovf));

   srf_host_model srf_host_model_i (.clock(clock), .reg_ptr_load(reg_ptr_load),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   ////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string w, input logic [7:0] x, input logic [7:0] g);
      n_tests++;
      if (g !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", w, x, g);
      end
   endtask

   task automatic rdchk(input string w, input logic [7:0] x);
      logic [7:0] v;
      srf_host_model_i.rd(v);
      chk(w, x, v);
   endtask

   // Waits for the staging path, bounded, then compares
   task automatic wait_fill(input logic [7:0] x);
      int i;
      for (i = 0; i < 40 && fill !== x; i++) @(negedge clock);
      chk("fill", x, fill);
   endtask

   task automatic push(input logic [7:0] st);
      int i;
      @(negedge clock);
      for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clock);
      st_in = st;
      for (i = 0; i < 6; i++) chan[16*i +: 16] = {8'h10 + 8'(i), st};
      sample_valid = 1'b1;
      @(negedge clock);
      sample_valid = 1'b0;
   endtask

   // Entry e of the overflow run: status, then channels ascending
   function automatic logic [15:0] ent(input int e);
      int j;
      j = e % 7;
      return {(j == 0) ? 8'h00 : 8'h10 + 8'(j - 1), 8'h20 + 8'(e / 7)};
   endfunction

   ////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // Hang guard; the full run needs well under a quarter of this
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      rst_n        = 1'b0;
      sample_valid = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      chk("ovf", 8'h00, {7'h00, ovf});
      chk("ready", 8'h01, {7'h00, ready});
      push(8'h5A);
      repeat (6) @(negedge clock);
      chk("fill", 8'h00, fill);
      srf_host_model_i.load(8'hFC);
      rdchk("select", 8'h00);
      srf_host_model_i.wr(8'hFD, 8'h55);
      srf_host_model_i.load(8'hFD);
      rdchk("fill reg", 8'h00);
      srf_host_model_i.load(8'h00);
      rdchk("unmapped", 8'h00);
      srf_host_model_i.wr(8'hFC, 8'hFF);
      srf_host_model_i.load(8'hFC);
      rdchk("select", 8'h7F);
      srf_host_model_i.wr(8'hFC, 8'h06);
      push(8'h5A);
      chk("ready", 8'h00, {7'h00, ready});
      // Second sample while unpacking must be dropped
      @(negedge clock);
      sample_valid = 1'b1;
      @(negedge clock);
      sample_valid = 1'b0;
      repeat (8) @(negedge clock);
      chk("fill", 8'h02, fill);
      srf_host_model_i.load(8'hFF);
      rdchk("high alone", 8'h10);
      wait_fill(8'h01);
      srf_host_model_i.load(8'hFF);
      rdchk("high alone", 8'h11);
      wait_fill(8'h00);
      srf_host_model_i.wr(8'hFC, 8'h7F);
      for (s = 0; s < 19; s++) push(8'h20 + 8'(s));
      wait_fill(8'h80);
      repeat (3) @(negedge clock);
      chk("ovf", 8'h01, {7'h00, ovf});
      srf_host_model_i.load(8'hFD);
      rdchk("fill reg", 8'h80);
      srf_host_model_i.load(8'hFE);
      for (e = 0; e < 128; e++) begin
         w = ent(e);
         rdchk("low", w[7:0]);
         rdchk("high", w[15:8]);
         if (e == 0) begin
            wait_fill(8'h7F);
            chk("ovf", 8'h00, {7'h00, ovf});
            chk("ptr", 8'hFE, reg_ptr);
         end
      end
      wait_fill(8'h00);
      rdchk("empty low", 8'h00);
      rdchk("empty high", 8'h00);
      chk("fill", 8'h00, fill);
      give_verdict();
   end
endmodule
`default_nettype wire
